// ---- hw/drsr_defines.svh ----
// Summary of operation
// - Gate-high code is six bits; 7.6 V at zero, 0.2 V per step, 20.2 V top.
// - Gate-high code resets to 0x16 (12 V); two-stage pump bit resets to zero.
// - Gate-low code is six bits; -5.6 V at zero, -0.2 V per step, -18.2 V bottom.
// - Gate-low code resets to 0x16 (-10 V); its upper two bits are unused.
// - Analog supply code is six bits, 4.2 V plus 0.1 V steps, resets to 0x1A.
// - Stored bit 7 high selects the internal temperature sensor over the external input.
// - Stored bit 6 high reloads working registers from stored copies once per second.
// - Stored bit 5 high turns on spread-spectrum of the switching clock.
// - Stored bits 3:2 set fault retry time, bits 1:0 set fault timing.
// - Three two-bit stored fields at 7:6, 5:4, 3:2 set start-up delays, 0 to 15 ms.
// - Stored delay bit 1 enables common-electrode temperature compensation; resets to zero.
`ifndef DRSR_DEFINES_SVH
`define DRSR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define DRSR_OFS_ANALOG      8'h13
`define DRSR_OFS_GATE_HIGH   8'h14
`define DRSR_OFS_GATE_LOW    8'h15
`define DRSR_OFS_STORED_GEN  8'h17
`define DRSR_OFS_STORED_DLY  8'h18

// ****************************************
// Fields and reset values
// ****************************************
`define DRSR_CODE_W          6
`define DRSR_PUMP_BIT        6
`define DRSR_RST_ANALOG      6'h1A
`define DRSR_RST_GATE_HIGH   6'h16
`define DRSR_RST_GATE_LOW    6'h16
`define DRSR_RST_STORED      8'h00

// ****************************************
// Level decode in millivolts
// ****************************************
`define DRSR_GH_BASE_MV      7600
`define DRSR_GH_STEP_MV      200
`define DRSR_GL_BASE_MV      5600
`define DRSR_GL_STEP_MV      200
`define DRSR_AN_BASE_MV      4200
`define DRSR_AN_STEP_MV      100

// ****************************************
// Timing
// ****************************************
`define DRSR_CLK_MHZ         50
`define DRSR_DELAY_STEP_US   5000
`define DRSR_DELAY_STEP_CYC  (`DRSR_DELAY_STEP_US * `DRSR_CLK_MHZ)
`define DRSR_RELOAD_MS       1000
`define DRSR_RELOAD_CYC      (`DRSR_RELOAD_MS * 1000 * `DRSR_CLK_MHZ)
`define DRSR_RELOAD_CNT_W    26
`define DRSR_DELAY_CYC_W     20

`endif

// ---- hw/drsr_pkg.sv ----
package drsr_pkg;

  // ****************************************
  // Stored general configuration byte
  // ****************************************
  typedef struct packed {
    logic       internal_sensor_sel;
    logic       periodic_reload_en;
    logic       spread_spectrum_on;
    logic       switch_rate_sel;
    logic [1:0] fault_retry_time;
    logic [1:0] fault_time_sel;
  } drsr_gen_cfg_t;

  // ****************************************
  // Stored delay and compensation byte
  // ****************************************
  typedef struct packed {
    logic [1:0] startup_delay_first;
    logic [1:0] startup_delay_second;
    logic [1:0] startup_delay_third;
    logic       common_temp_comp_en;
    logic       common_level_low_bit;
  } drsr_dly_cfg_t;

  // ****************************************
  // Decoded rail targets
  // ****************************************
  typedef struct packed {
    logic [15:0] gate_high_mv;
    logic [15:0] gate_low_neg_mv;
    logic [15:0] analog_mv;
    logic        two_stage_pump_sel;
  } drsr_rails_t;

endpackage : drsr_pkg

// ---- hw/drsr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drsr_defines.svh"

module drsr_regs #(
  parameter int unsigned RELOAD_CYCLES = `DRSR_RELOAD_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_wdata,
  output logic [7:0]                         reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic [7:0]                    stored_gen_in,
  input  wire logic [7:0]                    stored_dly_in,
  input  wire logic [7:0]                    stored_gate_high_in,
  input  wire logic [7:0]                    stored_gate_low_in,
  input  wire logic [7:0]                    stored_analog_in,
  input  wire logic                          stored_load,
  output drsr_pkg::drsr_rails_t              rails,
  output drsr_pkg::drsr_gen_cfg_t            gen_cfg,
  output drsr_pkg::drsr_dly_cfg_t            dly_cfg,
  output logic [`DRSR_DELAY_CYC_W-1:0]       startup_delay_cyc [3],
  output logic                               reload_pulse
);

  // ****************************************
  // State
  // ****************************************
  logic [`DRSR_CODE_W-1:0]      gate_high_q, gate_high_d;
  logic                         pump_q, pump_d;
  logic [`DRSR_CODE_W-1:0]      gate_low_q, gate_low_d;
  logic [`DRSR_CODE_W-1:0]      analog_q, analog_d;
  logic [7:0]                   stored_gen_q, stored_gen_d;
  logic [7:0]                   stored_dly_q, stored_dly_d;
  logic [`DRSR_RELOAD_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
  logic                         reload_q, reload_d;
  logic [7:0]                   rdata_q, rdata_d;
  logic                         rvalid_q, rvalid_d;
  drsr_pkg::drsr_rails_t        rails_q, rails_d;
  drsr_pkg::drsr_gen_cfg_t      gen_q;
  drsr_pkg::drsr_dly_cfg_t      dly_q;
  logic                         reload_now;

  // Last count of the one-second tick
  localparam logic [`DRSR_RELOAD_CNT_W-1:0] TICK_LAST = `DRSR_RELOAD_CNT_W'(RELOAD_CYCLES - 1);

  assign gen_q = drsr_pkg::drsr_gen_cfg_t'(stored_gen_q);
  assign dly_q = drsr_pkg::drsr_dly_cfg_t'(stored_dly_q);

  // ****************************************
  // Stored copies and one-second tick
  // ****************************************
  always_comb begin
    // Stored bytes share this clock, so they are sampled with no synchroniser
    stored_gen_d = stored_gen_in;
    stored_dly_d = stored_dly_in;
    tick_cnt_d   = tick_cnt_q;
    reload_d     = 1'b0;
    // One-second tick runs only while periodic reload is enabled
    if (gen_q.periodic_reload_en) begin
      if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_d = '0;
        reload_d   = 1'b1;
      end else begin
        tick_cnt_d = tick_cnt_q + 1'b1;
      end
    end else begin
      tick_cnt_d = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stored_gen_q <= `DRSR_RST_STORED;
      stored_dly_q <= `DRSR_RST_STORED;
      tick_cnt_q   <= '0;
      reload_q     <= 1'b0;
    end else begin
      stored_gen_q <= stored_gen_d;
      stored_dly_q <= stored_dly_d;
      tick_cnt_q   <= tick_cnt_d;
      reload_q     <= reload_d;
    end
  end

  // ****************************************
  // Working rail codes
  // ****************************************
  always_comb begin
    reload_now  = reload_q | stored_load;
    gate_high_d = gate_high_q;
    pump_d      = pump_q;
    gate_low_d  = gate_low_q;
    analog_d    = analog_q;
    if (reload_now) begin
      gate_high_d = stored_gate_high_in[`DRSR_CODE_W-1:0];
      pump_d      = stored_gate_high_in[`DRSR_PUMP_BIT];
      gate_low_d  = stored_gate_low_in[`DRSR_CODE_W-1:0];
      analog_d    = stored_analog_in[`DRSR_CODE_W-1:0];
    end
    // A software write in the same cycle wins over the reload
    if (reg_wr) begin
      if (reg_addr == `DRSR_OFS_GATE_HIGH) begin
        gate_high_d = reg_wdata[`DRSR_CODE_W-1:0];
        pump_d      = reg_wdata[`DRSR_PUMP_BIT];
      end else if (reg_addr == `DRSR_OFS_GATE_LOW) begin
        gate_low_d = reg_wdata[`DRSR_CODE_W-1:0];
      end else if (reg_addr == `DRSR_OFS_ANALOG) begin
        analog_d = reg_wdata[`DRSR_CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_high_q <= `DRSR_RST_GATE_HIGH;
      pump_q      <= 1'b0;
      gate_low_q  <= `DRSR_RST_GATE_LOW;
      analog_q    <= `DRSR_RST_ANALOG;
    end else begin
      gate_high_q <= gate_high_d;
      pump_q      <= pump_d;
      gate_low_q  <= gate_low_d;
      analog_q    <= analog_d;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    // Read data holds until the next read
    rvalid_d = reg_rd;
    rdata_d  = rdata_q;
    if (reg_rd) begin
      if (reg_addr == `DRSR_OFS_GATE_HIGH) begin
        rdata_d = {1'b0, pump_q, gate_high_q};
      end else if (reg_addr == `DRSR_OFS_GATE_LOW) begin
        rdata_d = {2'b00, gate_low_q};
      end else if (reg_addr == `DRSR_OFS_ANALOG) begin
        rdata_d = {2'b00, analog_q};
      end else if (reg_addr == `DRSR_OFS_STORED_GEN) begin
        rdata_d = stored_gen_q;
      end else if (reg_addr == `DRSR_OFS_STORED_DLY) begin
        rdata_d = stored_dly_q;
      end else begin
        // Unmapped addresses read as zero
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // Decoded rail targets
  // ****************************************
  always_comb begin
    // Targets lag their code register by one cycle
    rails_d.gate_high_mv       = 16'(`DRSR_GH_BASE_MV + `DRSR_GH_STEP_MV * int'(gate_high_q));
    rails_d.gate_low_neg_mv    = 16'(`DRSR_GL_BASE_MV + `DRSR_GL_STEP_MV * int'(gate_low_q));
    rails_d.analog_mv          = 16'(`DRSR_AN_BASE_MV + `DRSR_AN_STEP_MV * int'(analog_q));
    rails_d.two_stage_pump_sel = pump_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rails_q <= '0;
    end else begin
      rails_q <= rails_d;
    end
  end

  // ****************************************
  // Start-up delay decode
  // ****************************************
  logic [1:0] dly_code [3];
  assign dly_code[0] = dly_q.startup_delay_first;
  assign dly_code[1] = dly_q.startup_delay_second;
  assign dly_code[2] = dly_q.startup_delay_third;

  // Delay counts are registered so the outputs come from flip-flops
  for (genvar g = 0; g < 3; g++) begin : g_delay
    logic [`DRSR_DELAY_CYC_W-1:0] cyc_q, cyc_d;
    always_comb begin
      cyc_d = `DRSR_DELAY_CYC_W'(`DRSR_DELAY_STEP_CYC * int'(dly_code[g]));
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cyc_q <= '0;
      end else begin
        cyc_q <= cyc_d;
      end
    end
    assign startup_delay_cyc[g] = cyc_q;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rails        = rails_q;
  assign gen_cfg      = gen_q;
  assign dly_cfg      = dly_q;
  assign reg_rdata    = rdata_q;
  assign reg_rvalid   = rvalid_q;
  assign reload_pulse = reload_q;

endmodule : drsr_regs

`default_nettype wire

// ---- testbench/drsr_regs_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drsr_defines.svh"
module drsr_regs_props #(
  parameter int unsigned RELOAD_CYCLES = 20
) (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [7:0]                   reg_addr,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_wdata,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         reg_rvalid,
  input wire logic [7:0]                   stored_gen_in,
  input wire logic                         stored_load,
  input wire drsr_pkg::drsr_rails_t        rails,
  input wire drsr_pkg::drsr_gen_cfg_t      gen_cfg,
  input wire drsr_pkg::drsr_dly_cfg_t      dly_cfg,
  input wire logic [`DRSR_DELAY_CYC_W-1:0] startup_delay_cyc [3],
  input wire logic                         reload_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] run_q;
  logic [31:0] run_d;
  always_comb run_d = (reload_pulse || !gen_cfg.periodic_reload_en) ? 32'h0 : run_q + 32'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) run_q <= 32'h0;
    else run_q <= run_d;
  end
  // ****************************************
  // Rail decode, read port, config view, start-up delay and reload properties
  // ****************************************
  sequence s_wr(logic [7:0] x);
    reg_wr && reg_addr == x && !reload_pulse && !stored_load;
  endsequence
  sequence s_hold(logic [7:0] x);
    !(reg_wr && reg_addr == x) && !reload_pulse && !stored_load;
  endsequence
  property p_gh;
    s_wr(8'h14) ##1 s_hold(8'h14) |=> rails.gate_high_mv == 16'(7600 + 200 * $past(reg_wdata[5:0], 2))
      && rails.two_stage_pump_sel == $past(reg_wdata[6], 2);
  endproperty
  a_gh: assert property (p_gh) else $error("gate high decode wrong");
  property p_gl;
    s_wr(8'h15) ##1 s_hold(8'h15) |=> rails.gate_low_neg_mv == 16'(5600 + 200 * $past(reg_wdata[5:0], 2));
  endproperty
  a_gl: assert property (p_gl) else $error("gate low decode wrong");
  property p_rv;
    1'b1 |=> reg_rvalid == $past(reg_rd);
  endproperty
  a_rv: assert property (p_rv) else $error("read valid timing wrong");
  property p_unm;
    reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_ro;
    reg_rd && reg_addr == 8'h17 && $stable(stored_gen_in) && !$past(rst) |=> reg_rdata == $past(stored_gen_in);
  endproperty
  a_ro: assert property (p_ro) else $error("stored config read wrong");
  property p_gen;
    !$past(rst) && !$past(rst, 2) && $stable(stored_gen_in) && $past(stored_gen_in, 2) == stored_gen_in
      |-> gen_cfg == stored_gen_in;
  endproperty
  a_gen: assert property (p_gen) else $error("config view wrong");
  property p_dly;
    $stable(dly_cfg) && $past(dly_cfg, 2) == dly_cfg
      |-> startup_delay_cyc[0] == 20'(dly_cfg.startup_delay_first * 250000)
      && startup_delay_cyc[2] == 20'(dly_cfg.startup_delay_third * 250000);
  endproperty
  a_dly: assert property (p_dly) else $error("start-up delay wrong");
  property p_rld_on;
    reload_pulse |-> run_q + 1 >= RELOAD_CYCLES && run_q <= RELOAD_CYCLES;
  endproperty
  a_rld_on: assert property (p_rld_on) else $error("reload too early");
  property p_rld_due;
    run_q <= RELOAD_CYCLES + 1;
  endproperty
  a_rld_due: assert property (p_rld_due) else $error("reload missing");
endmodule : drsr_regs_props
bind drsr_regs drsr_regs_props #(.RELOAD_CYCLES(RELOAD_CYCLES)) u_props (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .stored_gen_in(stored_gen_in), .stored_load(stored_load), .rails(rails),
  .gen_cfg(gen_cfg), .dly_cfg(dly_cfg), .startup_delay_cyc(startup_delay_cyc), .reload_pulse(reload_pulse));
`default_nettype wire

// ---- testbench/display_rail_setting_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drsr_defines.svh"
module display_rail_setting_regs_tb_top;
  logic [7:0]                   a = 8'h00, wd = 8'h00, gi = 8'h00, di = 8'h00, hi = 8'h00, rdat;
  logic [7:0]                   lo = 8'h00, an = 8'h00;
  logic                         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ld = 1'b0, rv, rp;
  drsr_pkg::drsr_rails_t        rails;
  drsr_pkg::drsr_gen_cfg_t      gc;
  drsr_pkg::drsr_dly_cfg_t      dc;
  logic [`DRSR_DELAY_CYC_W-1:0] dcyc [3];
  int                           fail_count = 0, comparisons = 0, i, m [int];
  logic [31:0]                  lf = 32'h8BC32306;
  drsr_regs #(.RELOAD_CYCLES(20)) dut (.clk(clk), .rst(rst), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .stored_gen_in(gi), .stored_dly_in(di),
    .stored_gate_high_in(hi), .stored_gate_low_in(lo), .stored_analog_in(an), .stored_load(ld),
    .rails(rails), .gen_cfg(gc), .dly_cfg(dc), .startup_delay_cyc(dcyc), .reload_pulse(rp));
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction : rnd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rails();
    chk(rails.gate_high_mv, 7600 + 200 * (m[8'h14] & 63));
    chk(rails.two_stage_pump_sel, m[8'h14] >> 6);
    chk(rails.gate_low_neg_mv, 5600 + 200 * m[8'h15]);
    chk(rails.analog_mv, 4200 + 100 * m[8'h13]);
  endtask : chk_rails
  task automatic wrt(input logic [7:0] x, input logic [7:0] d);
    @(negedge clk);
    {a, wd, wr} = {x, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
    if (m.exists(x)) m[x] = d & (x == 8'h14 ? 8'h7F : 8'h3F);
  endtask : wrt
  task automatic rdc(input logic [7:0] x);
    @(negedge clk);
    {a, rd} = {x, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    chk(rv, 1);
    chk(rdat, m.exists(x) ? m[x] : x == 8'h17 ? gi : x == 8'h18 ? di : 0);
  endtask : rdc
  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial forever #10 clk = ~clk;
  initial begin
    m[8'h13] = 8'h1A;
    m[8'h14] = 8'h16;
    m[8'h15] = 8'h16;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (m[k]) rdc(8'(k));
    for (i = 0; i < 12; i++) begin
      wrt(8'h13 + 8'(i % 3), i < 3 ? 8'h00 : i < 6 ? 8'hFF : rnd());
      @(negedge clk);
      chk_rails();
      rdc(8'h13 + 8'(i % 3));
    end
    gi = rnd() & 8'hBF;
    di = rnd();
    wrt(8'h17, 8'hFF);
    wrt(8'h18, 8'h00);
    wrt(8'h30, 8'h55);
    rdc(8'h17);
    rdc(8'h18);
    rdc(8'h30);
    chk(gc, gi);
    for (i = 0; i < 4; i++) begin
      di = {2'(i), 2'(3 - i), 2'(i), 2'(i + 2)};
      repeat (3) @(negedge clk);
      chk(dcyc[0], i * 250000);
      chk(dcyc[1], (3 - i) * 250000);
      chk(dcyc[2], i * 250000);
      chk(dc.common_temp_comp_en, ((i + 2) >> 1) & 1);
      chk(dc.common_level_low_bit, i & 1);
    end
    hi = rnd();
    lo = rnd();
    an = rnd();
    ld = 1'b1;
    @(negedge clk);
    ld = 1'b0;
    m[8'h13] = an & 8'h3F;
    m[8'h14] = hi & 8'h7F;
    m[8'h15] = lo & 8'h3F;
    foreach (m[k]) rdc(8'(k));
    chk_rails();
    hi = rnd();
    lo = rnd();
    an = rnd();
    gi = 8'h40;
    for (i = 0; i < 100 && rp !== 1'b1; i++) @(negedge clk);
    chk(rp, 1);
    m[8'h13] = an & 8'h3F;
    m[8'h14] = hi & 8'h7F;
    m[8'h15] = lo & 8'h3F;
    gi = 8'h00;
    foreach (m[k]) rdc(8'(k));
    chk_rails();
    complete_run();
  end
endmodule : display_rail_setting_regs_tb_top
`default_nettype wire
